/* File: hdl/tic_ctrl_page_regs.sv */
// Behaviour
// - Shadowed selects apply at next frame start when busy, at once when idle
// - Reset restores every register default
// - Defaults valid after sequencer program load
// - Address 0x00 reads fixed family code
// - Address 0x01 reads mask revision code
// - Indirect memory address and data registers
// - Frame start/end markers, defaults 0x1e/0xe1
// - Line start/end markers, defaults 0xaa/0x55
// - Strap register: bits 5,6, rest zero
// - Straps sampled in scan after reset
// - First select: two fields, reset 0x30
// - Second select: same layout, reset 0x35
`timescale 1ns/1ps
module tic_ctrl_page_regs #(
    // Arbitrary identity values
    parameter logic [7:0] CHIP_FAMILY_CODE   = 8'h5a,
    parameter logic [7:0] MASK_REVISION_CODE = 8'h01
) (
    // Clock and reset
    input  wire logic            clk,
    input  wire logic            nrst,
    // Register access from serial engine
    input  tic_pkg::tic_reg_req_s reg_req,
    output logic [7:0]           reg_rdata,
    output logic                 reg_rvalid,
    output logic                 reg_wr_ignored,
    // Frame and sequencer status
    input  wire logic            frame_start,
    input  wire logic            acq_busy,
    input  wire logic            seq_load_done,
    // Strap pins
    input  wire logic            bus_addr_strap_bit0,
    input  wire logic            bus_addr_strap_bit1,
    output logic [1:0]           bus_addr_strap,
    output logic                 strap_scan_done,
    // Indirect memory engine
    input  wire logic            nvm_rd_valid,
    input  wire logic [7:0]      nvm_rd_data,
    output logic [7:0]           nvm_addr,
    output logic [7:0]           nvm_data,
    output logic                 nvm_addr_wr,
    output logic                 nvm_data_wr,
    // Video and modulator configuration
    output tic_pkg::tic_markers_s embedded_sync_markers,
    output tic_pkg::tic_sel_s    first_frame_sel,
    output tic_pkg::tic_sel_s    second_frame_sel
);

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic logic is_writable(input logic [7:0] a);
        unique case (a)
            tic_pkg::ADDR_NVM_ADDRESS,
            tic_pkg::ADDR_NVM_DATA,
            tic_pkg::ADDR_FRAME_START,
            tic_pkg::ADDR_FRAME_END,
            tic_pkg::ADDR_LINE_START,
            tic_pkg::ADDR_LINE_END,
            tic_pkg::ADDR_FIRST_SEL,
            tic_pkg::ADDR_SECOND_SEL: begin
                is_writable = 1'b1;
            end
            default: begin
                is_writable = 1'b0;
            end
        endcase
    endfunction

    function automatic logic hits(input logic        wr,
                                  input logic [7:0] a,
                                  input logic [7:0] target);
        hits = wr && (a == target);
    endfunction

    // ------------------------------------------------------------
    // Strap capture
    // ------------------------------------------------------------
    logic [1:0] strap_captured;

    tic_strap_capture u_strap (
        .clk        (clk),
        .nrst       (nrst),
        .strap_pins ({bus_addr_strap_bit1, bus_addr_strap_bit0}),
        .captured   (strap_captured),
        .done       (strap_scan_done)
    );

    // Reserved bits of the strap register stay zero
    logic [7:0] strap_word;

    always_comb begin
        strap_word = tic_pkg::RST_ZERO;
        strap_word[tic_pkg::STRAP_BIT0_POS] = strap_captured[0];
        strap_word[tic_pkg::STRAP_BIT1_POS] = strap_captured[1];
    end

    // ------------------------------------------------------------
    // Shadowed sample selects
    // ------------------------------------------------------------
    localparam int NUM_SEL = 2;
    localparam logic [7:0] SEL_ADDR [NUM_SEL] = '{
        tic_pkg::ADDR_FIRST_SEL,
        tic_pkg::ADDR_SECOND_SEL
    };
    localparam logic [7:0] SEL_RST [NUM_SEL] = '{
        tic_pkg::RST_FIRST_SEL,
        tic_pkg::RST_SECOND_SEL
    };

    tic_pkg::tic_sel_s sel_staged [NUM_SEL];
    tic_pkg::tic_sel_s sel_active [NUM_SEL];

    genvar gi;
    generate
        for (gi = 0; gi < NUM_SEL; gi++) begin : g_sel
            tic_shadow_sel #(
                .RST_SEL (tic_pkg::tic_sel_s'(SEL_RST[gi][3:0]))
            ) u_sel (
                .clk           (clk),
                .nrst          (nrst),
                .load_defaults (seq_load_done),
                .wr            (hits(reg_req.wr, reg_req.addr, SEL_ADDR[gi])),
                // Upper reserved nibble is never stored
                .wdata         (tic_pkg::tic_sel_s'(reg_req.wdata[3:0])),
                .acq_busy      (acq_busy),
                .frame_start   (frame_start),
                .staged        (sel_staged[gi]),
                .active        (sel_active[gi])
            );
        end
    endgenerate

    assign first_frame_sel  = sel_active[0];
    assign second_frame_sel = sel_active[1];

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    tic_pkg::tic_regs_state_s s_q;
    tic_pkg::tic_regs_state_s s_d;

    localparam tic_pkg::tic_markers_s MARKERS_RST = '{
        frame_start: tic_pkg::RST_FRAME_START,
        frame_end:   tic_pkg::RST_FRAME_END,
        line_start:  tic_pkg::RST_LINE_START,
        line_end:    tic_pkg::RST_LINE_END
    };

    localparam tic_pkg::tic_regs_state_s STATE_RST = '{
        nvm_addr:    tic_pkg::RST_ZERO,
        nvm_data:    tic_pkg::RST_ZERO,
        markers:     MARKERS_RST,
        rdata:       tic_pkg::RST_ZERO,
        rvalid:      1'b0,
        wr_ignored:  1'b0,
        nvm_addr_wr: 1'b0,
        nvm_data_wr: 1'b0
    };

    // ------------------------------------------------------------
    // Write path
    // ------------------------------------------------------------
    always_comb begin
        s_d             = s_q;
        s_d.rvalid      = 1'b0;
        s_d.wr_ignored  = 1'b0;
        s_d.nvm_addr_wr = 1'b0;
        s_d.nvm_data_wr = 1'b0;

        if (seq_load_done) begin
            // Program load brings the documented defaults
            s_d.nvm_addr = STATE_RST.nvm_addr;
            s_d.nvm_data = STATE_RST.nvm_data;
            s_d.markers  = MARKERS_RST;
        end else if (reg_req.wr) begin
            if (!is_writable(reg_req.addr)) begin
                // Read-only and unmapped writes leave state alone
                s_d.wr_ignored = 1'b1;
            end
            if (hits(1'b1, reg_req.addr, tic_pkg::ADDR_NVM_ADDRESS)) begin
                s_d.nvm_addr    = reg_req.wdata;
                s_d.nvm_addr_wr = 1'b1;
            end
            if (hits(1'b1, reg_req.addr, tic_pkg::ADDR_NVM_DATA)) begin
                s_d.nvm_data    = reg_req.wdata;
                s_d.nvm_data_wr = 1'b1;
            end
            if (hits(1'b1, reg_req.addr, tic_pkg::ADDR_FRAME_START)) begin
                s_d.markers.frame_start = reg_req.wdata;
            end
            if (hits(1'b1, reg_req.addr, tic_pkg::ADDR_FRAME_END)) begin
                s_d.markers.frame_end = reg_req.wdata;
            end
            if (hits(1'b1, reg_req.addr, tic_pkg::ADDR_LINE_START)) begin
                s_d.markers.line_start = reg_req.wdata;
            end
            if (hits(1'b1, reg_req.addr, tic_pkg::ADDR_LINE_END)) begin
                s_d.markers.line_end = reg_req.wdata;
            end
        end

        // Memory read-back beats a host write in the same cycle
        if (nvm_rd_valid && !seq_load_done) begin
            s_d.nvm_data = nvm_rd_data;
        end

        // --------------------------------------------------------
        // Read path, one cycle latency
        // --------------------------------------------------------
        if (reg_req.rd) begin
            s_d.rvalid = 1'b1;
            unique case (reg_req.addr)
                tic_pkg::ADDR_CHIP_FAMILY: begin
                    s_d.rdata = CHIP_FAMILY_CODE;
                end
                tic_pkg::ADDR_MASK_REVISION: begin
                    s_d.rdata = MASK_REVISION_CODE;
                end
                tic_pkg::ADDR_NVM_ADDRESS: begin
                    s_d.rdata = s_q.nvm_addr;
                end
                tic_pkg::ADDR_NVM_DATA: begin
                    s_d.rdata = s_q.nvm_data;
                end
                tic_pkg::ADDR_FRAME_START: begin
                    s_d.rdata = s_q.markers.frame_start;
                end
                tic_pkg::ADDR_FRAME_END: begin
                    s_d.rdata = s_q.markers.frame_end;
                end
                tic_pkg::ADDR_LINE_START: begin
                    s_d.rdata = s_q.markers.line_start;
                end
                tic_pkg::ADDR_LINE_END: begin
                    s_d.rdata = s_q.markers.line_end;
                end
                tic_pkg::ADDR_STRAP_HIGH: begin
                    s_d.rdata = strap_word;
                end
                tic_pkg::ADDR_FIRST_SEL: begin
                    // Host sees the pending value, not the one in use
                    s_d.rdata = {tic_pkg::SEL_RSVD_VALUE, sel_staged[0]};
                end
                tic_pkg::ADDR_SECOND_SEL: begin
                    s_d.rdata = {tic_pkg::SEL_RSVD_VALUE, sel_staged[1]};
                end
                default: begin
                    // Unmapped space reads as zero
                    s_d.rdata = tic_pkg::RST_ZERO;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_q <= STATE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign reg_rdata             = s_q.rdata;
    assign reg_rvalid            = s_q.rvalid;
    assign reg_wr_ignored        = s_q.wr_ignored;
    assign nvm_addr              = s_q.nvm_addr;
    assign nvm_data              = s_q.nvm_data;
    assign nvm_addr_wr           = s_q.nvm_addr_wr;
    assign nvm_data_wr           = s_q.nvm_data_wr;
    assign embedded_sync_markers = s_q.markers;
    assign bus_addr_strap        = strap_captured;

endmodule

/* File: hdl/tic_pkg.sv */
package tic_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CHIP_FAMILY   = 8'h00;
    localparam logic [7:0] ADDR_MASK_REVISION = 8'h01;
    localparam logic [7:0] ADDR_NVM_ADDRESS   = 8'h11;
    localparam logic [7:0] ADDR_NVM_DATA      = 8'h12;
    localparam logic [7:0] ADDR_FRAME_START   = 8'h1c;
    localparam logic [7:0] ADDR_FRAME_END     = 8'h1d;
    localparam logic [7:0] ADDR_LINE_START    = 8'h1e;
    localparam logic [7:0] ADDR_LINE_END      = 8'h1f;
    localparam logic [7:0] ADDR_STRAP_HIGH    = 8'h20;
    localparam logic [7:0] ADDR_FIRST_SEL     = 8'h22;
    localparam logic [7:0] ADDR_SECOND_SEL    = 8'h25;

    // ------------------------------------------------------------
    // Reset values and fields
    // ------------------------------------------------------------
    localparam logic [7:0] RST_ZERO         = 8'h00;
    localparam logic [7:0] RST_FRAME_START  = 8'h1e;
    localparam logic [7:0] RST_FRAME_END    = 8'he1;
    localparam logic [7:0] RST_LINE_START   = 8'haa;
    localparam logic [7:0] RST_LINE_END     = 8'h55;
    localparam logic [7:0] RST_FIRST_SEL    = 8'h30;
    localparam logic [7:0] RST_SECOND_SEL   = 8'h35;
    localparam logic [3:0] SEL_RSVD_VALUE   = 4'h3;
    localparam int         STRAP_BIT0_POS   = 5;
    localparam int         STRAP_BIT1_POS   = 6;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS     = 10;
    localparam int STRAP_SCAN_NS     = 100;
    localparam int STRAP_SCAN_CYCLES =
        (STRAP_SCAN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] STRAP_CNT_LAST = 8'(STRAP_SCAN_CYCLES - 1);

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic {
        TIC_SCAN = 1'b0,
        TIC_HELD = 1'b1
    } tic_scan_e;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } tic_reg_req_s;

    typedef struct packed {
        logic [7:0] frame_start;
        logic [7:0] frame_end;
        logic [7:0] line_start;
        logic [7:0] line_end;
    } tic_markers_s;

    typedef struct packed {
        logic [1:0] modulator_one;
        logic [1:0] modulator_zero;
    } tic_sel_s;

    typedef struct packed {
        logic [7:0]   nvm_addr;
        logic [7:0]   nvm_data;
        tic_markers_s markers;
        logic [7:0]   rdata;
        logic         rvalid;
        logic         wr_ignored;
        logic         nvm_addr_wr;
        logic         nvm_data_wr;
    } tic_regs_state_s;

    typedef struct packed {
        tic_sel_s staged;
        tic_sel_s active;
    } tic_shadow_state_s;

    typedef struct packed {
        tic_scan_e  phase;
        logic [1:0] sync1;
        logic [1:0] sync2;
        logic [7:0] cnt;
        logic [1:0] captured;
    } tic_strap_state_s;

endpackage

/* File: hdl/tic_shadow_sel.sv */
`timescale 1ns/1ps
module tic_shadow_sel #(
    parameter tic_pkg::tic_sel_s RST_SEL = '0
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         nrst,
    // Control
    input  wire logic         load_defaults,
    input  wire logic         wr,
    input  tic_pkg::tic_sel_s wdata,
    input  wire logic         acq_busy,
    input  wire logic         frame_start,
    // Values
    output tic_pkg::tic_sel_s staged,
    output tic_pkg::tic_sel_s active
);

    tic_pkg::tic_shadow_state_s s_q;
    tic_pkg::tic_shadow_state_s s_d;

    always_comb begin
        s_d = s_q;
        if (load_defaults) begin
            s_d.staged = RST_SEL;
            s_d.active = RST_SEL;
        end else begin
            if (frame_start) begin
                s_d.active = s_q.staged;
            end
            if (wr) begin
                s_d.staged = wdata;
                // Idle write lands at once; busy write waits for a frame start
                if (!acq_busy) begin
                    s_d.active = wdata;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_q <= {RST_SEL, RST_SEL};
        end else begin
            s_q <= s_d;
        end
    end

    assign staged = s_q.staged;
    assign active = s_q.active;

endmodule

/* File: hdl/tic_strap_capture.sv */
`timescale 1ns/1ps
module tic_strap_capture (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       nrst,
    // Strap pins, bit1 high
    input  wire logic [1:0] strap_pins,
    // Captured value
    output logic [1:0]      captured,
    output logic            done
);

    tic_pkg::tic_strap_state_s s_q;
    tic_pkg::tic_strap_state_s s_d;

    always_comb begin
        s_d       = s_q;
        s_d.sync1 = strap_pins;
        s_d.sync2 = s_q.sync1;
        unique case (s_q.phase)
            tic_pkg::TIC_SCAN: begin
                // Pull-ups need time to settle after release
                if (s_q.cnt == tic_pkg::STRAP_CNT_LAST) begin
                    s_d.captured = s_q.sync2;
                    s_d.phase    = tic_pkg::TIC_HELD;
                end else begin
                    s_d.cnt = s_q.cnt + 8'h01;
                end
            end
            tic_pkg::TIC_HELD: begin
                s_d.cnt = s_q.cnt;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_q <= '{phase: tic_pkg::TIC_SCAN, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    assign captured = s_q.captured;
    assign done     = (s_q.phase == tic_pkg::TIC_HELD);

endmodule

/* File: tb/tic_ctrl_page_regs_monitor.sv */
`timescale 1ns/1ps
module tic_ctrl_page_regs_monitor #(
    parameter logic [7:0] CHIP_FAMILY_CODE   = 8'h5a,
    parameter logic [7:0] MASK_REVISION_CODE = 8'h01
) (
    // Clock and reset
    input  wire logic            clk,
    input  wire logic            nrst,
    // Register port
    input  tic_pkg::tic_reg_req_s reg_req,
    input  logic [7:0]           reg_rdata,
    input  logic                 reg_rvalid,
    input  logic                 reg_wr_ignored,
    // Status and outputs
    input  wire logic            frame_start,
    input  wire logic            acq_busy,
    input  wire logic            seq_load_done,
    input  logic [7:0]           nvm_addr,
    input  logic                 nvm_addr_wr,
    input  logic [7:0]           nvm_data,
    input  logic                 nvm_data_wr,
    input  wire logic            nvm_rd_valid,
    input  wire logic [7:0]      nvm_rd_data,
    input  tic_pkg::tic_markers_s embedded_sync_markers,
    input  tic_pkg::tic_sel_s    first_frame_sel,
    input  tic_pkg::tic_sel_s    second_frame_sel
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // Writes in a load cycle lose to defaults, so they are left out
    wire logic       wr_ok = reg_req.wr && !seq_load_done;
    wire logic [7:0] a     = reg_req.addr;

    a_family_read: assert property (
        reg_req.rd && a == 8'h00 |=> reg_rvalid && reg_rdata == CHIP_FAMILY_CODE)
        else $error("family code read wrong");
    a_revision_read: assert property (
        reg_req.rd && a == 8'h01 |=> reg_rvalid && reg_rdata == MASK_REVISION_CODE)
        else $error("revision code read wrong");
    a_strap_reserved: assert property (
        reg_req.rd && a == 8'h20 |=> reg_rdata[7] == 1'b0 && reg_rdata[4:0] == 5'h00)
        else $error("strap reserved bits set");
    a_sel_reserved: assert property (
        reg_req.rd && (a == 8'h22 || a == 8'h25) |=> reg_rdata[7:4] == 4'h3)
        else $error("select upper nibble wrong");
    a_ro_write_drop: assert property (
        wr_ok && (a == 8'h00 || a == 8'h01 || a == 8'h20) |=> reg_wr_ignored)
        else $error("read-only write not flagged");
    a_marker_write: assert property (
        wr_ok && a == 8'h1c |=> embedded_sync_markers.frame_start == $past(reg_req.wdata))
        else $error("frame start marker not written");
    a_line_end_write: assert property (
        wr_ok && a == 8'h1f |=> embedded_sync_markers.line_end == $past(reg_req.wdata))
        else $error("line end marker not written");
    a_nvm_addr_write: assert property (
        wr_ok && a == 8'h11 |=> nvm_addr_wr && nvm_addr == $past(reg_req.wdata))
        else $error("indirect address not written");
    a_nvm_data_write: assert property (
        wr_ok && a == 8'h12 && !nvm_rd_valid
        |=> nvm_data_wr && nvm_data == $past(reg_req.wdata))
        else $error("indirect data not written");
    a_nvm_readback: assert property (
        nvm_rd_valid && !seq_load_done |=> nvm_data == $past(nvm_rd_data))
        else $error("memory read-back not captured");
    a_shadow_hold: assert property (
        acq_busy && !frame_start && !seq_load_done
        |=> $stable(first_frame_sel) && $stable(second_frame_sel))
        else $error("select changed mid frame");
    a_idle_select: assert property (
        !acq_busy && !frame_start && wr_ok && a == 8'h22
        |=> first_frame_sel == $past(reg_req.wdata[3:0]))
        else $error("idle select write not applied");
    a_load_defaults: assert property (
        seq_load_done |=> embedded_sync_markers == 32'h1ee1aa55
            && first_frame_sel == 4'h0 && second_frame_sel == 4'h5)
        else $error("defaults not restored on load");
endmodule

bind tic_ctrl_page_regs tic_ctrl_page_regs_monitor #(
    .CHIP_FAMILY_CODE  (CHIP_FAMILY_CODE),
    .MASK_REVISION_CODE(MASK_REVISION_CODE)
) tic_ctrl_page_regs_monitor_i (
    .clk(clk), .nrst(nrst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .reg_wr_ignored(reg_wr_ignored),
    .frame_start(frame_start), .acq_busy(acq_busy), .seq_load_done(seq_load_done),
    .nvm_addr(nvm_addr), .nvm_addr_wr(nvm_addr_wr),
    .nvm_data(nvm_data), .nvm_data_wr(nvm_data_wr),
    .nvm_rd_valid(nvm_rd_valid), .nvm_rd_data(nvm_rd_data),
    .embedded_sync_markers(embedded_sync_markers),
    .first_frame_sel(first_frame_sel), .second_frame_sel(second_frame_sel)
);

/* File: tb/tic_host_model.sv */
`timescale 1ns/1ps
module tic_host_model (
    // Clock
    input  wire logic            clk,
    // Register port
    output tic_pkg::tic_reg_req_s reg_req,
    input  wire logic [7:0]      reg_rdata,
    input  wire logic            reg_rvalid
);
    initial begin
        reg_req = '{wr: 1'b0, rd: 1'b0, addr: 8'hff, wdata: 8'hff};
    end

    // Idle bus shows the inverse of the last value, never a stale match
    task automatic park();
        reg_req.wr    = 1'b0;
        reg_req.rd    = 1'b0;
        reg_req.addr  = ~reg_req.addr;
        reg_req.wdata = ~reg_req.wdata;
    endtask

    // Callers only write mapped addresses
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_req.addr  = a;
        reg_req.wdata = d;
        reg_req.wr    = 1'b1;
        @(negedge clk);
        park();
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        int n;
        @(negedge clk);
        reg_req.addr = a;
        reg_req.rd   = 1'b1;
        @(negedge clk);
        park();
        n = 0;
        while (reg_rvalid !== 1'b1 && n < 4) begin
            @(negedge clk);
            n++;
        end
        d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
    endtask
endmodule

/* File: tb/tb.sv */
`timescale 1ns/1ps
module tb;
    localparam logic [7:0] FAMILY = 8'h5a;
    localparam logic [7:0] REV    = 8'h01;
    logic                  clk, nrst, frame_start, acq_busy, seq_load_done;
    logic                  strap0, strap1, nvm_rd_valid, reg_rvalid, reg_wr_ignored;
    logic                  strap_scan_done, nvm_addr_wr, nvm_data_wr;
    logic [7:0]            nvm_rd_data, reg_rdata, nvm_addr, nvm_data;
    logic [1:0]            bus_addr_strap;
    tic_pkg::tic_reg_req_s reg_req;
    tic_pkg::tic_markers_s markers;
    tic_pkg::tic_sel_s     first_sel, second_sel;
    int                    fail_count = 0;
    int                    samples_checked = 0;
    int                    n;
    logic [7:0]            ta [11] = '{8'h00, 8'h01, 8'h11, 8'h12, 8'h1c, 8'h1d,
                                       8'h1e, 8'h1f, 8'h22, 8'h25, 8'h30};
    logic [7:0]            tv [11] = '{FAMILY, REV, 8'h00, 8'h00, 8'h1e, 8'he1,
                                       8'haa, 8'h55, 8'h30, 8'h35, 8'h00};

    tic_ctrl_page_regs #(.CHIP_FAMILY_CODE(FAMILY), .MASK_REVISION_CODE(REV))
    tic_ctrl_page_regs_i (
        .clk(clk), .nrst(nrst), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .reg_wr_ignored(reg_wr_ignored),
        .frame_start(frame_start), .acq_busy(acq_busy), .seq_load_done(seq_load_done),
        .bus_addr_strap_bit0(strap0), .bus_addr_strap_bit1(strap1),
        .bus_addr_strap(bus_addr_strap), .strap_scan_done(strap_scan_done),
        .nvm_rd_valid(nvm_rd_valid), .nvm_rd_data(nvm_rd_data), .nvm_addr(nvm_addr),
        .nvm_data(nvm_data), .nvm_addr_wr(nvm_addr_wr), .nvm_data_wr(nvm_data_wr),
        .embedded_sync_markers(markers), .first_frame_sel(first_sel),
        .second_frame_sel(second_sel));
    tic_host_model tic_host_model_i (
        .clk(clk), .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        tic_host_model_i.rd_reg(a, d);
        check(d, exp);
    endtask

    // Reset then count edges until the straps are captured
    task automatic reset_and_scan();
        nrst = 1'b0;
        repeat (6) @(negedge clk);
        nrst = 1'b1;
        n = 0;
        while (strap_scan_done !== 1'b1 && n < 100) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        {frame_start, acq_busy, seq_load_done, nvm_rd_valid} = 4'h0;
        nvm_rd_data = 8'h00;
        strap0 = 1'b1;
        strap1 = 1'b1;
        reset_and_scan();
        check(8'(n), 8'(tic_pkg::STRAP_SCAN_CYCLES));
        check({6'h00, bus_addr_strap}, 8'h03);
        rd_check(8'h20, 8'h60);
        for (int i = 0; i < 11; i++) rd_check(ta[i], tv[i]);
        $display("test defaults done");
        // Non-shadowed writes only while idle
        for (int i = 2; i < 8; i++) tic_host_model_i.wr_reg(ta[i], ta[i] ^ 8'ha5);
        for (int i = 2; i < 8; i++) rd_check(ta[i], ta[i] ^ 8'ha5);
        check(nvm_addr, 8'hb4);
        check(markers.frame_start, 8'hb9);
        check(markers.line_start, 8'hbb);
        tic_host_model_i.wr_reg(8'h22, 8'hff);
        rd_check(8'h22, 8'h3f);
        check({4'h0, first_sel}, 8'h0f);
        $display("test writes done");
        for (int i = 0; i < 3; i++) tic_host_model_i.wr_reg(8'h20 >> (i * 5), 8'ha5);
        rd_check(8'h00, FAMILY);
        rd_check(8'h01, REV);
        rd_check(8'h20, 8'h60);
        $display("test read-only done");
        @(negedge clk) acq_busy = 1'b1;
        tic_host_model_i.wr_reg(8'h25, 8'h02);
        rd_check(8'h25, 8'h32);
        check({4'h0, second_sel}, 8'h05);
        @(negedge clk) frame_start = 1'b1;
        @(negedge clk) frame_start = 1'b0;
        check({4'h0, second_sel}, 8'h02);
        // Busy write meeting a frame start: old pending value goes live
        fork
            tic_host_model_i.wr_reg(8'h22, 8'h01);
            @(negedge clk) frame_start = 1'b1;
        join
        frame_start = 1'b0;
        check({4'h0, first_sel}, 8'h0f);
        @(negedge clk) frame_start = 1'b1;
        @(negedge clk) frame_start = 1'b0;
        check({4'h0, first_sel}, 8'h01);
        acq_busy = 1'b0;
        $display("test shadow done");
        nvm_rd_data = 8'h9c;
        nvm_rd_valid = 1'b1;
        @(negedge clk) nvm_rd_valid = 1'b0;
        nvm_rd_data = 8'h63;
        rd_check(8'h12, 8'h9c);
        check(nvm_data, 8'h9c);
        @(negedge clk) seq_load_done = 1'b1;
        @(negedge clk) seq_load_done = 1'b0;
        rd_check(8'h1d, 8'he1);
        rd_check(8'h25, 8'h35);
        check(markers.frame_end, 8'he1);
        check({4'h0, first_sel}, 8'h00);
        $display("test load done");
        tic_host_model_i.wr_reg(8'h1c, 8'h11);
        strap1 = 1'b0;
        reset_and_scan();
        check(8'(n), 8'(tic_pkg::STRAP_SCAN_CYCLES));
        rd_check(8'h1c, 8'h1e);
        rd_check(8'h20, 8'h20);
        check({6'h00, bus_addr_strap}, 8'h01);
        $display("test second reset done");
        tally_and_finish();
    end

    initial begin
        #200000;
        fail_count++;
        tally_and_finish();
    end
endmodule
